// ===== ctt_pkg.sv
package ctt_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int PRE_W = 13;

    // register offsets
    localparam logic [3:0] REG_CTRL_ONE = 4'h0;
    localparam logic [3:0] REG_CTRL_TWO = 4'h1;
    localparam logic [3:0] REG_CMP_A_LO = 4'h2;
    localparam logic [3:0] REG_CMP_A_HI = 4'h3;
    localparam logic [3:0] REG_CMP_B_LO = 4'h4;
    localparam logic [3:0] REG_CMP_B_HI = 4'h5;
    localparam logic [3:0] REG_CMP_C_LO = 4'h6;
    localparam logic [3:0] REG_CMP_C_HI = 4'h7;
    localparam logic [3:0] REG_COUNT_LO = 4'h8;
    localparam logic [3:0] REG_COUNT_HI = 4'h9;
    localparam logic [3:0] REG_STATUS = 4'ha;

    // compare_timer_control_one fields
    localparam int B_START_CONTROL = 0;
    localparam int B_START_SELECT = 1;
    localparam int B_BOTH_EDGES = 2;
    localparam int B_EDGE_SELECT = 3;
    localparam int B_CYCLE_SELECT = 4;
    localparam int B_MODE_PULSE = 5;
    localparam int B_PULSE_OUT_SEL = 6;
    localparam int B_SOFT_RESET = 7;

    // compare_timer_control_two fields
    localparam int B_FF_INIT = 0;
    localparam int B_CLK_SEL_LO = 1;
    localparam int B_REG_COUNT_LO = 4;
    localparam int B_TRIG_DISABLE = 6;

    // status fields
    localparam int B_ST_RUNNING = 0;
    localparam int B_ST_FF = 1;

    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    localparam logic [15:0] CMP_RST = 16'hffff;
    localparam logic [15:0] CNT_RST = 16'h0000;

    localparam logic [2:0] CLK_UNUSABLE = 3'h6;
    localparam logic [2:0] CLK_PIN = 3'h7;

    localparam logic [1:0] REGS_A = 2'h0;
    localparam logic [1:0] REGS_AB = 2'h1;
    localparam logic [1:0] REGS_ABC = 2'h2;

    typedef enum logic {CTT_STOP, CTT_COUNT} ctt_run_t;

    // divide exponent of each prescaler tap before halving
    function automatic logic [3:0] ctt_tap_shift(input logic [2:0] code);
        logic [3:0] s;
        s = 4'h1;
        unique case (code)
            3'h0: s = 4'hb;
            3'h1: s = 4'h7;
            3'h2: s = 4'h5;
            3'h3: s = 4'h3;
            3'h4: s = 4'h2;
            default: s = 4'h1;
        endcase
        return s;
    endfunction : ctt_tap_shift

endpackage : ctt_pkg

// ===== ctt_evt_if.sv
`timescale 1ns/10ps
interface ctt_evt_if;
    logic tick;
    logic act_edge;
    logic opp_edge;
    logic any_edge;
    modport pre (output tick);
    modport edg (output act_edge, output opp_edge, output any_edge);
    modport core (input tick, input act_edge, input opp_edge,
        input any_edge);
endinterface : ctt_evt_if

// ===== ctt_prescaler.sv
`timescale 1ns/10ps
module ctt_prescaler
    import ctt_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic [2:0] clk_sel_in,
    input wire logic halving_in,
    ctt_evt_if.pre evt
);
    logic [PRE_W-1:0] div_q;
    logic [3:0] shift;
    logic [PRE_W-1:0] mask;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 13'h0001;
        end
    end

    // halving moves every tap one divide step slower
    assign shift = 4'(ctt_tap_shift(clk_sel_in) + {3'h0, halving_in});
    assign mask = 13'((13'h0001 << shift) - 13'h0001);
    // no tick for the unusable code or the pin clock
    assign evt.tick = (clk_sel_in < CLK_UNUSABLE) && ((div_q & mask) == mask);
endmodule : ctt_prescaler

// ===== ctt_edge_detect.sv
`timescale 1ns/10ps
module ctt_edge_detect
    import ctt_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic timer_pin_in,
    input wire logic pin_is_input_in,
    input wire logic trig_disable_in,
    input wire logic edge_select_in,
    ctt_evt_if.edg evt
);
    logic level;
    logic prev_q;
    logic rise;
    logic fall;

    // a disabled or output-configured pin reads as constant 0
    assign level = timer_pin_in & pin_is_input_in & ~trig_disable_in;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;
    assign evt.act_edge = edge_select_in ? fall : rise;
    assign evt.opp_edge = edge_select_in ? rise : fall;
    assign evt.any_edge = rise | fall;
endmodule : ctt_edge_detect

// ===== ctt_timer.sv
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module ctt_timer
    import ctt_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    input wire logic prescaler_halving_in,
    input wire logic timer_pin_in,
    input wire logic pin_is_input_in,
    output logic timer_match_irq_out,
    output logic timer_ff_out
);
    logic [7:0] ctrl_one_q;
    logic [7:0] ctrl_two_q;
    logic [7:0] stage_q;
    logic [CNT_W-1:0] cmp_a_q;
    logic [CNT_W-1:0] cmp_b_q;
    logic [CNT_W-1:0] cmp_c_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    ctt_run_t run_q;
    ctt_run_t run_d;
    logic irq_q;
    logic irq_d;
    logic ff_q;
    logic ff_d;
    logic [7:0] rdata_q;

    ctt_evt_if evt ();

    wire start_on = ctrl_one_q[B_START_CONTROL];
    wire trig_start = ctrl_one_q[B_START_SELECT];
    wire both_edges = trig_start & ctrl_one_q[B_BOTH_EDGES];
    wire one_shot = ctrl_one_q[B_CYCLE_SELECT];
    wire mode_pulse = ctrl_one_q[B_MODE_PULSE];
    wire [2:0] clk_sel = ctrl_two_q[B_CLK_SEL_LO +: 3];
    wire [1:0] reg_count = ctrl_two_q[B_REG_COUNT_LO +: 2];
    wire pin_clock = (clk_sel == CLK_PIN) && !mode_pulse;

    wire wr_one = reg_wr_in && (reg_addr_in == REG_CTRL_ONE);
    wire wr_two = reg_wr_in && (reg_addr_in == REG_CTRL_TWO);
    wire soft_rst = wr_one && reg_wdata_in[B_SOFT_RESET];
    wire wr_lo = reg_wr_in && ((reg_addr_in == REG_CMP_A_LO)
        || (reg_addr_in == REG_CMP_B_LO) || (reg_addr_in == REG_CMP_C_LO));
    wire [15:0] wr_word = {reg_wdata_in, stage_q};
    wire b_open = mode_pulse && ((reg_count == REGS_AB)
        || (reg_count == REGS_ABC));
    wire c_open = mode_pulse && (reg_count == REGS_ABC);
    wire wr_a = reg_wr_in && (reg_addr_in == REG_CMP_A_HI);
    wire wr_b = reg_wr_in && (reg_addr_in == REG_CMP_B_HI) && b_open;
    wire wr_c = reg_wr_in && (reg_addr_in == REG_CMP_C_HI) && c_open;

    // last register in use ends the period; timer modes only use A
    wire [CNT_W-1:0] last_cmp = !mode_pulse ? cmp_a_q :
        (reg_count == REGS_ABC) ? cmp_c_q :
        (reg_count == REGS_AB) ? cmp_b_q : cmp_a_q;
    wire cnt_en = pin_clock ? evt.act_edge : evt.tick;
    wire counting = (run_q == CTT_COUNT) && cnt_en;
    wire hit_last = counting && (cnt_q == last_cmp);
    wire hit_mid = counting && mode_pulse && (reg_count != REGS_A)
        && ((cnt_q == cmp_a_q) || (b_open && c_open && cnt_q == cmp_b_q));

    ctt_prescaler u_pre (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_sel_in(clk_sel),
        .halving_in(prescaler_halving_in),
        .evt(evt.pre)
    );

    ctt_edge_detect u_edge (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .timer_pin_in(timer_pin_in),
        .pin_is_input_in(pin_is_input_in),
        .trig_disable_in(ctrl_two_q[B_TRIG_DISABLE]),
        .edge_select_in(ctrl_one_q[B_EDGE_SELECT]),
        .evt(evt.edg)
    );

    always_comb begin
        run_d = run_q;
        cnt_d = cnt_q;
        // a match in the reset cycle still raises its interrupt
        irq_d = hit_last;
        ff_d = ff_q;
        if (hit_last || hit_mid) begin
            ff_d = mode_pulse ? ~ff_q : ff_q;
        end
        if (!start_on) begin
            run_d = CTT_STOP;
            cnt_d = CNT_RST;
        end else if (trig_start) begin
            if (evt.act_edge) begin
                // successive mode: a trigger while running stops it
                if (run_q == CTT_COUNT && !one_shot) begin
                    run_d = CTT_STOP;
                end else begin
                    run_d = CTT_COUNT;
                end
                cnt_d = CNT_RST;
            end else if (both_edges && evt.opp_edge) begin
                run_d = CTT_STOP;
                cnt_d = CNT_RST;
            end else if (hit_last) begin
                cnt_d = CNT_RST;
                run_d = one_shot ? CTT_STOP : CTT_COUNT;
            end else if (counting) begin
                cnt_d = cnt_q + 16'h0001;
            end
        end else begin
            run_d = CTT_COUNT;
            if (evt.any_edge && !pin_clock) begin
                cnt_d = CNT_RST;
            end else if (hit_last) begin
                cnt_d = CNT_RST;
            end else if (counting) begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
        if (wr_two) begin
            ff_d = reg_wdata_in[B_FF_INIT];
        end
        if (soft_rst) begin
            run_d = CTT_STOP;
            cnt_d = CNT_RST;
            ff_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            run_q <= CTT_STOP;
            cnt_q <= CNT_RST;
            irq_q <= 1'b0;
            ff_q <= 1'b0;
        end else begin
            run_q <= run_d;
            cnt_q <= cnt_d;
            irq_q <= irq_d;
            ff_q <= ff_d;
        end
    end

    // control registers; the soft reset bit is never stored
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_one_q <= CTRL_ONE_RST;
            ctrl_two_q <= CTRL_TWO_RST;
        end else if (soft_rst) begin
            ctrl_one_q <= CTRL_ONE_RST;
            ctrl_two_q <= CTRL_TWO_RST;
        end else begin
            if (wr_one) begin
                ctrl_one_q <= reg_wdata_in & 8'h7f;
            end
            if (wr_two) begin
                ctrl_two_q <= reg_wdata_in;
            end
        end
    end

    // compare values survive soft reset so software need not reload them
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stage_q <= 8'h00;
            cmp_a_q <= CMP_RST;
            cmp_b_q <= CMP_RST;
            cmp_c_q <= CMP_RST;
        end else begin
            if (wr_lo) begin
                stage_q <= reg_wdata_in;
            end
            if (wr_a) begin
                cmp_a_q <= wr_word;
            end
            if (wr_b) begin
                cmp_b_q <= wr_word;
            end
            if (wr_c) begin
                cmp_c_q <= wr_word;
            end
        end
    end

    wire [7:0] status = {6'h00, ff_q, run_q == CTT_COUNT};
    wire [7:0] rd_mux =
        (reg_addr_in == REG_CTRL_ONE) ? ctrl_one_q :
        (reg_addr_in == REG_CTRL_TWO) ? ctrl_two_q :
        (reg_addr_in == REG_COUNT_LO) ? cnt_q[7:0] :
        (reg_addr_in == REG_COUNT_HI) ? cnt_q[15:8] :
        (reg_addr_in == REG_STATUS) ? status : 8'h00;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd_in ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign timer_match_irq_out = irq_q;
    assign timer_ff_out = ff_q;

    property p_soft_reset;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        soft_rst |=> (cnt_q == CNT_RST) && !ff_q && (run_q == CTT_STOP)
            && (ctrl_one_q == CTRL_ONE_RST);
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not clear timer state");

    property p_soft_bit_zero;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (reg_rd_in && reg_addr_in == REG_CTRL_ONE) |=> !reg_rdata_out[7];
    endproperty
    a_soft_bit_zero: assert property (p_soft_bit_zero)
        else $error("soft reset bit read back as one");

    property p_sw_match;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (start_on && !trig_start && !mode_pulse && hit_last
            && !evt.any_edge && !soft_rst)
            |=> timer_match_irq_out && (cnt_q == CNT_RST)
            ##1 !timer_match_irq_out;
    endproperty
    a_sw_match: assert property (p_sw_match)
        else $error("match A did not interrupt and clear");

    property p_idle_stop;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (!start_on && !wr_one) [*2] |-> (cnt_q == CNT_RST)
            && (run_q == CTT_STOP);
    endproperty
    a_idle_stop: assert property (p_idle_stop)
        else $error("counter not stopped while idle");

    property p_b_guard;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == REG_CMP_B_HI && !b_open)
            |=> $stable(cmp_b_q);
    endproperty
    a_b_guard: assert property (p_b_guard)
        else $error("compare B written while locked");

    property p_trig_off;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        $past(ctrl_two_q[B_TRIG_DISABLE]) && ctrl_two_q[B_TRIG_DISABLE]
            |-> !evt.any_edge;
    endproperty
    a_trig_off: assert property (p_trig_off)
        else $error("pin edge seen while trigger disabled");

    property p_ff_init;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (wr_two && !soft_rst) |=> timer_ff_out == $past(reg_wdata_in[0]);
    endproperty
    a_ff_init: assert property (p_ff_init)
        else $error("output flip-flop did not take init value");

    sequence s_oneshot_hit;
        start_on && trig_start && one_shot && hit_last && !evt.act_edge
            && !(both_edges && evt.opp_edge) && !soft_rst;
    endsequence
    property p_oneshot;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        s_oneshot_hit |=> (run_q == CTT_STOP) && (cnt_q == CNT_RST);
    endproperty
    a_oneshot: assert property (p_oneshot)
        else $error("one-shot did not stop at match");

    property p_opp_edge;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (start_on && both_edges && evt.opp_edge && !soft_rst)
            |=> (run_q == CTT_STOP) && (cnt_q == CNT_RST);
    endproperty
    a_opp_edge: assert property (p_opp_edge)
        else $error("opposite edge did not stop counter");

    property p_commit;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (reg_wr_in && reg_addr_in == REG_CMP_A_LO) ##1
            (reg_wr_in && reg_addr_in == REG_CMP_A_HI)
            |=> cmp_a_q == {$past(reg_wdata_in), $past(reg_wdata_in, 2)};
    endproperty
    a_commit: assert property (p_commit)
        else $error("compare A not committed low then high");

endmodule : ctt_timer

// ===== ctt_pin_model.sv
`timescale 1ns/10ps
// far-side driver of the timer input pin; it moves only after a clock edge
// and, when slow, lags the request by four cycles like a sluggish source
module ctt_pin_model (
    input wire logic sys_clk_in,
    input wire logic level_req_in,
    input wire logic slow_in,
    output logic pin_out
);
    logic [1:0] lag_q;

    initial begin
        pin_out = 1'b0;
        lag_q = 2'h0;
    end

    always @(posedge sys_clk_in) begin
        if (level_req_in !== pin_out) begin
            if (!slow_in || lag_q == 2'h3) begin
                pin_out <= level_req_in;
                lag_q <= 2'h0;
            end else begin
                lag_q <= lag_q + 2'h1;
            end
        end
    end
endmodule : ctt_pin_model

// ===== ctt_timer_bench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
    err_total++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module ctt_timer_bench
    import ctt_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [ADDR_W-1:0] reg_addr_in = 4'h0;
    logic [DATA_W-1:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [DATA_W-1:0] reg_rdata_out;
    logic prescaler_halving_in = 1'b0;
    logic timer_pin_in;
    logic pin_is_input_in = 1'b0;
    logic timer_match_irq_out;
    logic timer_ff_out;
    logic pin_req = 1'b0;
    logic pin_slow = 1'b0;
    int err_total = 0;
    int n_tests = 0;
    int seed = 32'h6b0d;
    int cyc = 0, irq_cnt = 0, last_irq = 0, prev_irq = 0, tog = 0, tog_seen = 0;
    logic ff_prev = 1'b0;
    logic [7:0] d;
    int iv, tg, base, lst;

    always #20 sys_clk_in = ~sys_clk_in;

    ctt_timer u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .prescaler_halving_in(prescaler_halving_in),
        .timer_pin_in(timer_pin_in), .pin_is_input_in(pin_is_input_in),
        .timer_match_irq_out(timer_match_irq_out),
        .timer_ff_out(timer_ff_out));

    ctt_pin_model u_pin (.sys_clk_in(sys_clk_in), .level_req_in(pin_req),
        .slow_in(pin_slow), .pin_out(timer_pin_in));

    // toggles are counted before the interrupt so a toggle on the closing
    // match lands in the period that it ends
    always @(posedge sys_clk_in) begin
        cyc++;
        if (timer_ff_out !== ff_prev) tog++;
        ff_prev = timer_ff_out;
        if (timer_match_irq_out === 1'b1) begin
            irq_cnt++;
            prev_irq = last_irq;
            last_irq = cyc;
            tog_seen = tog;
            tog = 0;
        end
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    initial begin
        #(40 * 100000);
        err_total++;
        end_sim();
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask : rd

    task automatic chk_rd(input string nm, input logic [3:0] a,
        input logic [7:0] msk, input logic [7:0] ex);
        rd(a, d);
        `CHK(nm, ex, d & msk)
    endtask : chk_rd

    // low and high bytes go back to back with the strobe held between them
    task automatic wcmp(input logic [3:0] lo, input logic [15:0] v);
        @(posedge sys_clk_in);
        reg_addr_in <= lo;
        reg_wdata_in <= v[7:0];
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_addr_in <= 4'(lo + 4'h1);
        reg_wdata_in <= v[15:8];
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wcmp

    function automatic logic [7:0] c2(input logic td, input logic [1:0] rc,
        input logic [2:0] ck, input logic ff);
        return {1'b0, td, rc, ck, ff};
    endfunction : c2

    function automatic int tap(input int code);
        case (code)
            0: return 11;
            1: return 7;
            2: return 5;
            3: return 3;
            4: return 2;
            default: return 1;
        endcase
    endfunction : tap

    task automatic measure(output int v, output int t);
        int k;
        k = 0;
        base = irq_cnt;
        while (irq_cnt < base + 3 && k < 20000) begin
            @(posedge sys_clk_in);
            k++;
        end
        if (k >= 20000) err_total++;
        v = last_irq - prev_irq;
        t = tog_seen;
    endtask : measure

    task automatic pin_to(input logic v);
        int k;
        pin_slow <= 1'($random(seed));
        pin_req <= v;
        for (k = 0; k < 20 && timer_pin_in !== v; k++) @(posedge sys_clk_in);
        repeat (6) @(posedge sys_clk_in);
    endtask : pin_to

    // settings change only with the timer idle and the trigger disabled
    task automatic run_timer(input int code, input logic hv,
        input logic [15:0] cv);
        wr(REG_CTRL_ONE, 8'h00);
        prescaler_halving_in <= hv;
        wr(REG_CTRL_TWO, c2(1'b1, REGS_A, 3'(code), 1'b0));
        wcmp(REG_CMP_A_LO, cv);
        wr(REG_CTRL_ONE, 8'h01);
        measure(iv, tg);
        `CHK("period", (int'(cv) + 1) << (tap(code) + hv), iv)
        chk_rd("count", REG_COUNT_HI, 8'hff, cv[15:8]);
        rd(REG_COUNT_LO, d);
        `CHK("count_lo", 1'b1, d <= cv[7:0])
        wr(REG_CTRL_ONE, 8'h00);
    endtask : run_timer

    initial begin
        repeat (16) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        chk_rd("ctrl_one", REG_CTRL_ONE, 8'hff, CTRL_ONE_RST);
        chk_rd("ctrl_two", REG_CTRL_TWO, 8'hff, CTRL_TWO_RST);
        chk_rd("cmp_wo", REG_CMP_A_LO, 8'hff, 8'h00);
        chk_rd("unmapped", 4'hb, 8'hff, 8'h00);
        wr(REG_CTRL_TWO, 8'h5a);
        chk_rd("ctrl_two_rw", REG_CTRL_TWO, 8'h7f, 8'h5a);
        wr(REG_CTRL_TWO, c2(1'b1, REGS_A, 3'h5, 1'b1));
        repeat (2) @(posedge sys_clk_in);
        #1;
        `CHK("ff_set", 1'b1, timer_ff_out)
        chk_rd("ff_status", REG_STATUS, 8'h02, 8'h02);
        wr(REG_CTRL_TWO, c2(1'b1, REGS_A, 3'h5, 1'b0));
        repeat (2) @(posedge sys_clk_in);
        #1;
        `CHK("ff_clr", 1'b0, timer_ff_out)
        wr(REG_CTRL_ONE, 8'h80);
        chk_rd("soft_rst_rd", REG_CTRL_ONE, 8'h80, 8'h00);
        for (int c = 0; c < 6; c++) run_timer(c, 1'b0, 16'h0001);
        run_timer(5, 1'b1, 16'h0001);
        run_timer(3, 1'b1, 16'h0002);
        repeat (3) run_timer(5, 1'b0, 16'(2 + $unsigned($random(seed)) % 7));
        wr(REG_CTRL_TWO, c2(1'b1, REGS_A, CLK_UNUSABLE, 1'b0));
        wr(REG_CTRL_ONE, 8'h01);
        base = irq_cnt;
        repeat (300) @(posedge sys_clk_in);
        `CHK("no_tick", base, irq_cnt)
        for (int rc = 0; rc < 3; rc++) begin
            wr(REG_CTRL_ONE, 8'h00);
            wr(REG_CTRL_TWO, c2(1'b1, 2'(rc), 3'h5, 1'b0));
            wr(REG_CTRL_ONE, 8'h20);
            wcmp(REG_CMP_A_LO, 16'h0002);
            wcmp(REG_CMP_B_LO, 16'h0004);
            wcmp(REG_CMP_C_LO, 16'h0006);
            wr(REG_CTRL_ONE, 8'h21);
            measure(iv, tg);
            lst = 2 + 2 * rc;
            `CHK("pulse_period", (lst + 1) * 2, iv)
            `CHK("pulse_toggles", rc + 1, tg)
        end
        wr(REG_CTRL_ONE, 8'h00);
        wr(REG_CTRL_TWO, c2(1'b1, REGS_AB, 3'h5, 1'b0));
        wcmp(REG_CMP_B_LO, 16'h0009);
        wr(REG_CTRL_ONE, 8'h20);
        wr(REG_CTRL_ONE, 8'h21);
        measure(iv, tg);
        `CHK("b_refused", 10, iv)
        wr(REG_CTRL_ONE, 8'h80);
        repeat (2) @(posedge sys_clk_in);
        #1;
        `CHK("srst_ff", 1'b0, timer_ff_out)
        chk_rd("srst_two", REG_CTRL_TWO, 8'hff, 8'h00);
        chk_rd("srst_cnt", REG_COUNT_LO, 8'hff, 8'h00);
        base = irq_cnt;
        repeat (100) @(posedge sys_clk_in);
        `CHK("srst_stop", base, irq_cnt)
        pin_is_input_in <= 1'b1;
        wr(REG_CTRL_TWO, c2(1'b0, REGS_A, 3'h5, 1'b0));
        wcmp(REG_CMP_A_LO, 16'h0003);
        wr(REG_CTRL_ONE, 8'h03);
        chk_rd("trig_wait", REG_STATUS, 8'h01, 8'h00);
        pin_to(1'b1);
        chk_rd("trig_start", REG_STATUS, 8'h01, 8'h01);
        measure(iv, tg);
        `CHK("trig_period", 8, iv)
        pin_to(1'b0);
        chk_rd("opp_ignored", REG_STATUS, 8'h01, 8'h01);
        pin_to(1'b1);
        chk_rd("trig_stop", REG_STATUS, 8'h01, 8'h00);
        pin_to(1'b0);
        pin_to(1'b1);
        chk_rd("trig_again", REG_STATUS, 8'h01, 8'h01);
        wr(REG_CTRL_ONE, 8'h00);
        chk_rd("sw_stop", REG_STATUS, 8'h01, 8'h00);
        chk_rd("sw_stop_cnt", REG_COUNT_LO, 8'hff, 8'h00);
        wr(REG_CTRL_ONE, 8'h0b);
        pin_to(1'b0);
        chk_rd("fall_start", REG_STATUS, 8'h01, 8'h01);
        wr(REG_CTRL_ONE, 8'h00);
        wr(REG_CTRL_ONE, 8'h13);
        base = irq_cnt;
        pin_to(1'b1);
        repeat (40) @(posedge sys_clk_in);
        `CHK("one_shot", base + 1, irq_cnt)
        chk_rd("one_shot_idle", REG_STATUS, 8'h01, 8'h00);
        pin_to(1'b0);
        pin_to(1'b1);
        repeat (40) @(posedge sys_clk_in);
        `CHK("one_shot_re", base + 2, irq_cnt)
        wr(REG_CTRL_ONE, 8'h00);
        wr(REG_CTRL_ONE, 8'h07);
        pin_to(1'b0);
        pin_to(1'b1);
        pin_to(1'b0);
        chk_rd("both_stop", REG_STATUS, 8'h01, 8'h00);
        wr(REG_CTRL_ONE, 8'h00);
        wr(REG_CTRL_TWO, c2(1'b1, REGS_A, 3'h5, 1'b0));
        wr(REG_CTRL_ONE, 8'h03);
        pin_to(1'b1);
        chk_rd("trig_off", REG_STATUS, 8'h01, 8'h00);
        wr(REG_CTRL_ONE, 8'h00);
        wr(REG_CTRL_TWO, c2(1'b0, REGS_A, 3'h5, 1'b0));
        wcmp(REG_CMP_A_LO, 16'h0200);
        wr(REG_CTRL_ONE, 8'h05);
        repeat (200) @(posedge sys_clk_in);
        pin_to(1'b0);
        chk_rd("sw_both", REG_STATUS, 8'h01, 8'h01);
        rd(REG_COUNT_LO, d);
        `CHK("edge_clr", 1'b1, d < 8'h20)
        wr(REG_CTRL_ONE, 8'h00);
        wr(REG_CTRL_TWO, c2(1'b0, REGS_A, CLK_PIN, 1'b0));
        wcmp(REG_CMP_A_LO, 16'h0100);
        wr(REG_CTRL_ONE, 8'h01);
        repeat (3) begin
            pin_to(1'b1);
            pin_to(1'b0);
        end
        chk_rd("evt_rise", REG_COUNT_LO, 8'hff, 8'h03);
        wr(REG_CTRL_ONE, 8'h00);
        wr(REG_CTRL_ONE, 8'h09);
        repeat (2) begin
            pin_to(1'b1);
            pin_to(1'b0);
        end
        chk_rd("evt_fall", REG_COUNT_LO, 8'hff, 8'h02);
        end_sim();
    end
endmodule : ctt_timer_bench
